//--- logic/rafc_top.sv
// regeneration avoidance frequency compensation, one control clock
// assumes drive inputs come from logic on i_ref_clk and i_drive.tick pulses once per control cycle
//
// Behaviour
// - select 0 off, 1 always on, 2 on only at constant speed
// - when enabled, raise frequency while bus voltage is at or above level
// - level accepts 300 to 800 V; default 400 or 780 by class
// - outside deceleration compensation never exceeds limit; limit 0 to 10 Hz, default 6
// - in deceleration hold limit until output frequency falls to half limit
// - compensation never lifts output frequency above maximum output frequency
// - limit setting 9999 removes the compensation limit
// - voltage gain 0 to 200 percent, default 100, larger responds faster
// - separate frequency gain 0 to 200 percent scales the correction
// - stall prevention requested whenever avoidance is actively raising frequency
`timescale 1ns/1ps
`default_nettype none
`include "rafc_regs.svh"

module rafc_top #(
  parameter bit P_CLASS_400V = 1'b0
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire rafc_pkg::rafc_drive_in_type i_drive,
  input wire rafc_pkg::rafc_reg_req_type i_reg,
  output logic [31:0] o_rd_data,
  output logic [15:0] o_comp_freq,
  output logic o_regen_active,
  output logic o_stall_prev_req
);
  import rafc_pkg::*;

  localparam logic [9:0] LEVEL_RST = P_CLASS_400V ? `RAFC_RST_LEVEL_HIGH : `RAFC_RST_LEVEL_LOW;

  rafc_state_type s_q;
  rafc_state_type s_d;

  logic enabled;
  logic over_level;
  logic limit_on;
  logic [10:0] volt_err;
  logic [26:0] gain_prod;
  logic [15:0] step;
  logic [15:0] headroom;

  function automatic logic [7:0] clamp_gain(input logic [31:0] v);
    clamp_gain = (v > 32'(`RAFC_GAIN_MAX)) ? `RAFC_GAIN_MAX : v[7:0];
  endfunction : clamp_gain

  always_comb begin
    enabled = 1'b0;
    unique case (s_q.sel)
      `RAFC_SEL_ALWAYS: enabled = 1'b1;
      `RAFC_SEL_CONST: enabled = (i_drive.ramp == RAFC_RAMP_CONST);
      default: enabled = 1'b0;
    endcase
  end

  assign over_level = (i_drive.bus_volt >= s_q.level);
  assign limit_on = (s_q.limit != `RAFC_LIMIT_OFF);
  assign volt_err = {1'b0, i_drive.bus_volt} - {1'b0, s_q.level} + 11'h001;
  assign gain_prod = 27'(volt_err) * 27'(s_q.vgain) * 27'(s_q.fgain);
  assign step = 16'(gain_prod >> `RAFC_GAIN_SHIFT);
  assign headroom = (i_drive.out_freq >= s_q.maxf) ? 16'h0000 : s_q.maxf - i_drive.out_freq;

  always_comb begin
    logic [16:0] cand;
    logic [16:0] total;
    cand = 17'h00000;
    total = 17'h00000;
    s_d = s_q;
    s_d.rdata = 32'h00000000;

    if (i_reg.wr) begin
      unique case (i_reg.addr)
        `RAFC_OFS_SELECT: begin
          if (i_reg.wdata[1:0] != 2'h3) begin
            s_d.sel = i_reg.wdata[1:0];
          end
        end
        `RAFC_OFS_LEVEL: begin
          if (i_reg.wdata < 32'(`RAFC_LEVEL_MIN)) begin
            s_d.level = `RAFC_LEVEL_MIN;
          end else if (i_reg.wdata > 32'(`RAFC_LEVEL_MAX)) begin
            s_d.level = `RAFC_LEVEL_MAX;
          end else begin
            s_d.level = i_reg.wdata[9:0];
          end
        end
        `RAFC_OFS_LIMIT: begin
          if (i_reg.wdata == 32'(`RAFC_LIMIT_OFF)) begin
            s_d.limit = `RAFC_LIMIT_OFF;
          end else if (i_reg.wdata > 32'(`RAFC_LIMIT_MAX)) begin
            s_d.limit = `RAFC_LIMIT_MAX;
          end else begin
            s_d.limit = i_reg.wdata[15:0];
          end
        end
        `RAFC_OFS_VGAIN: s_d.vgain = clamp_gain(i_reg.wdata);
        `RAFC_OFS_FGAIN: s_d.fgain = clamp_gain(i_reg.wdata);
        `RAFC_OFS_MAXF: s_d.maxf = i_reg.wdata[15:0];
        default: begin
        end
      endcase
    end

    if (i_reg.rd) begin
      unique case (i_reg.addr)
        `RAFC_OFS_SELECT: s_d.rdata = 32'(s_q.sel);
        `RAFC_OFS_LEVEL: s_d.rdata = 32'(s_q.level);
        `RAFC_OFS_LIMIT: s_d.rdata = 32'(s_q.limit);
        `RAFC_OFS_VGAIN: s_d.rdata = 32'(s_q.vgain);
        `RAFC_OFS_FGAIN: s_d.rdata = 32'(s_q.fgain);
        `RAFC_OFS_MAXF: s_d.rdata = 32'(s_q.maxf);
        `RAFC_OFS_STATUS: begin
          s_d.rdata[`RAFC_STAT_ACTIVE] = s_q.active;
          s_d.rdata[`RAFC_STAT_HOLD] = s_q.hold;
          s_d.rdata[`RAFC_STAT_ENABLED] = enabled;
        end
        `RAFC_OFS_COMP: s_d.rdata = 32'(s_q.comp);
        default: s_d.rdata = 32'h00000000;
      endcase
    end

    if (i_drive.tick) begin
      if (!enabled) begin
        cand = (s_q.sel == `RAFC_SEL_OFF || s_q.comp < `RAFC_DECAY_STEP) ? 17'h00000
               : 17'(s_q.comp - `RAFC_DECAY_STEP);
        s_d.active = 1'b0;
        s_d.hold = 1'b0;
      end else if (over_level) begin
        cand = 17'(s_q.comp) + 17'(step);
        s_d.active = 1'b1;
      end else begin
        cand = (s_q.comp < `RAFC_DECAY_STEP) ? 17'h00000 : 17'(s_q.comp - `RAFC_DECAY_STEP);
        s_d.active = 1'b0;
      end

      if (enabled && limit_on) begin
        if (i_drive.ramp == RAFC_RAMP_DECEL) begin
          if (s_q.hold || cand > 17'(s_q.limit)) begin
            cand = 17'(s_q.limit);
            s_d.hold = 1'b1;
          end
          if (i_drive.out_freq <= (s_q.limit >> 1)) begin
            s_d.hold = 1'b0;
          end
        end else begin
          s_d.hold = 1'b0;
          if (cand > 17'(s_q.limit)) begin
            cand = 17'(s_q.limit);
          end
        end
      end else begin
        s_d.hold = 1'b0;
      end

      if (cand > 17'(headroom)) begin
        cand = 17'(headroom);
      end
      s_d.comp = cand[15:0];
      total = 17'(i_drive.out_freq) + cand;
      s_d.freq_out = total[15:0];
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q.sel <= `RAFC_RST_SELECT;
      s_q.level <= LEVEL_RST;
      s_q.limit <= `RAFC_RST_LIMIT;
      s_q.vgain <= `RAFC_RST_GAIN;
      s_q.fgain <= `RAFC_RST_GAIN;
      s_q.maxf <= `RAFC_RST_MAXF;
      s_q.comp <= 16'h0000;
      s_q.freq_out <= 16'h0000;
      s_q.hold <= 1'b0;
      s_q.active <= 1'b0;
      s_q.rdata <= 32'h00000000;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rd_data = s_q.rdata;
  assign o_comp_freq = s_q.freq_out;
  assign o_regen_active = s_q.active;
  assign o_stall_prev_req = s_q.active;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  property p_off_clears;
    i_drive.tick && s_q.sel == `RAFC_SEL_OFF |=> s_q.comp == 16'h0000 && !o_regen_active;
  endproperty
  a_off_clears: assert property (p_off_clears) else $error("comp not cleared when off");

  property p_const_only;
    i_drive.tick && s_q.sel == `RAFC_SEL_CONST && i_drive.ramp != RAFC_RAMP_CONST |=> !o_regen_active;
  endproperty
  a_const_only: assert property (p_const_only) else $error("active outside constant speed");

  property p_raise;
    i_drive.tick && enabled && over_level && !limit_on && 17'(s_q.comp) + 17'(step) <= 17'(headroom)
      |=> s_q.comp == $past(s_q.comp) + $past(step) && o_regen_active;
  endproperty
  a_raise: assert property (p_raise) else $error("compensation did not rise by step");

  property p_level_range;
    i_reg.wr && i_reg.addr == `RAFC_OFS_LEVEL |=> s_q.level >= `RAFC_LEVEL_MIN && s_q.level <= `RAFC_LEVEL_MAX;
  endproperty
  a_level_range: assert property (p_level_range) else $error("level out of range");

  property p_limit;
    i_drive.tick && enabled && limit_on && i_drive.ramp != RAFC_RAMP_DECEL |=> s_q.comp <= $past(s_q.limit);
  endproperty
  a_limit: assert property (p_limit) else $error("compensation above limit");

  property p_hold;
    i_drive.tick && enabled && limit_on && i_drive.ramp == RAFC_RAMP_DECEL && s_q.hold
      && s_q.limit <= headroom |=> s_q.comp == $past(s_q.limit);
  endproperty
  a_hold: assert property (p_hold) else $error("limit not held in deceleration");

  property p_max;
    i_drive.tick && i_drive.out_freq <= s_q.maxf |=> o_comp_freq <= $past(s_q.maxf);
  endproperty
  a_max: assert property (p_max) else $error("frequency above maximum");

  property p_gain_range;
    i_reg.wr && (i_reg.addr == `RAFC_OFS_VGAIN || i_reg.addr == `RAFC_OFS_FGAIN)
      |=> s_q.vgain <= `RAFC_GAIN_MAX && s_q.fgain <= `RAFC_GAIN_MAX;
  endproperty
  a_gain_range: assert property (p_gain_range) else $error("gain above range");

  property p_stall;
    i_drive.tick && enabled && over_level |=> o_stall_prev_req ##0 o_regen_active;
  endproperty
  a_stall: assert property (p_stall) else $error("stall prevention not requested");

  property p_decay;
    i_drive.tick && enabled && !over_level && s_q.comp != 16'h0000 && !s_q.hold
      |=> s_q.comp < $past(s_q.comp);
  endproperty
  a_decay: assert property (p_decay) else $error("compensation did not decay");

  property p_sel_legal;
    s_q.sel != 2'h3;
  endproperty
  a_sel_legal: assert property (p_sel_legal) else $error("select holds unused code");

  property p_below_idle;
    i_drive.tick && enabled && !over_level |=> !o_regen_active;
  endproperty
  a_below_idle: assert property (p_below_idle) else $error("active below level");

  property p_level_legal;
    s_q.level >= `RAFC_LEVEL_MIN
      && s_q.level <= `RAFC_LEVEL_MAX;
  endproperty
  a_level_legal: assert property (p_level_legal) else $error("level register out of range");

  property p_limit_legal;
    s_q.limit <= `RAFC_LIMIT_MAX
      || s_q.limit == `RAFC_LIMIT_OFF;
  endproperty
  a_limit_legal: assert property (p_limit_legal) else $error("limit register out of range");

  property p_sum;
    i_drive.tick |=> o_comp_freq == $past(i_drive.out_freq) + s_q.comp;
  endproperty
  a_sum: assert property (p_sum) else $error("output is not frequency plus compensation");

  property p_decel_cap;
    i_drive.tick && enabled && limit_on && i_drive.ramp == RAFC_RAMP_DECEL
      |=> s_q.comp <= $past(s_q.limit);
  endproperty
  a_decel_cap: assert property (p_decel_cap) else $error("compensation above limit in deceleration");

  property p_hold_release;
    i_drive.tick && enabled && limit_on && i_drive.ramp == RAFC_RAMP_DECEL
      && i_drive.out_freq <= (s_q.limit >> 1) |=> !s_q.hold;
  endproperty
  a_hold_release: assert property (p_hold_release) else $error("hold kept below half limit");

  property p_hold_only_decel;
    i_drive.tick && i_drive.ramp != RAFC_RAMP_DECEL |=> !s_q.hold;
  endproperty
  a_hold_only_decel: assert property (p_hold_only_decel) else $error("hold outside deceleration");

  property p_no_limit_hold;
    i_drive.tick && enabled && !limit_on |=> !s_q.hold;
  endproperty
  a_no_limit_hold: assert property (p_no_limit_hold) else $error("hold while limit bypassed");

  property p_zero_gain;
    i_drive.tick && enabled && over_level && (s_q.vgain == 8'h00 || s_q.fgain == 8'h00) && !limit_on
      && s_q.comp <= headroom |=> s_q.comp == $past(s_q.comp);
  endproperty
  a_zero_gain: assert property (p_zero_gain) else $error("compensation moved with zero gain");

  property p_fgain_legal;
    s_q.fgain <= `RAFC_GAIN_MAX;
  endproperty
  a_fgain_legal: assert property (p_fgain_legal) else $error("frequency gain out of range");

  property p_stall_off;
    i_drive.tick && !enabled |=> !o_stall_prev_req;
  endproperty
  a_stall_off: assert property (p_stall_off) else $error("stall prevention while disabled");

  property p_quiet;
    !i_drive.tick
      |=> $stable(s_q.comp) && $stable(o_comp_freq) && $stable(o_regen_active);
  endproperty
  a_quiet: assert property (p_quiet) else $error("outputs moved without a tick");

  c_active: cover property (i_drive.tick && enabled && over_level ##1 o_regen_active);
  c_decay: cover property (i_drive.tick && enabled && !over_level && s_q.comp != 16'h0000);
  c_hold: cover property (s_q.hold ##1 !s_q.hold);
  c_at_limit: cover property (limit_on && s_q.comp == s_q.limit && s_q.comp != 16'h0000);
  c_at_max: cover property (o_comp_freq == s_q.maxf && s_q.comp != 16'h0000);

endmodule : rafc_top

`default_nettype wire

//--- logic/rafc_regs.svh
// register map, reset values and fixed figures of the regeneration avoidance block
// assumes one byte-addressed word per register on the plain register port
`ifndef RAFC_REGS_SVH
`define RAFC_REGS_SVH

`define RAFC_ADDR_W 8
`define RAFC_DATA_W 32

`define RAFC_OFS_SELECT 8'h00
`define RAFC_OFS_LEVEL 8'h04
`define RAFC_OFS_LIMIT 8'h08
`define RAFC_OFS_VGAIN 8'h0C
`define RAFC_OFS_FGAIN 8'h10
`define RAFC_OFS_MAXF 8'h14
`define RAFC_OFS_STATUS 8'h18
`define RAFC_OFS_COMP 8'h1C

`define RAFC_SEL_OFF 2'h0
`define RAFC_SEL_ALWAYS 2'h1
`define RAFC_SEL_CONST 2'h2
`define RAFC_RST_SELECT 2'h0

`define RAFC_LEVEL_MIN 10'h12C
`define RAFC_LEVEL_MAX 10'h320
`define RAFC_RST_LEVEL_LOW 10'h190
`define RAFC_RST_LEVEL_HIGH 10'h30C

`define RAFC_LIMIT_MAX 16'h03E8
`define RAFC_LIMIT_OFF 16'h270F
`define RAFC_RST_LIMIT 16'h0258

`define RAFC_GAIN_MAX 8'hC8
`define RAFC_RST_GAIN 8'h64

`define RAFC_RST_MAXF 16'h2EE0

`define RAFC_GAIN_SHIFT 12
`define RAFC_DECAY_STEP 16'h0001

`define RAFC_STAT_ACTIVE 0
`define RAFC_STAT_HOLD 1
`define RAFC_STAT_ENABLED 2

`endif

//--- logic/rafc_pkg.sv
// types shared by the regeneration avoidance block
// frequencies in 0.01 Hz steps, voltages in 1 V steps
`default_nettype none
package rafc_pkg;

  typedef enum logic [3:0] {
    RAFC_RAMP_STOP = 4'b0001,
    RAFC_RAMP_ACCEL = 4'b0010,
    RAFC_RAMP_CONST = 4'b0100,
    RAFC_RAMP_DECEL = 4'b1000
  } rafc_ramp_type;

  typedef struct packed {
    logic tick;
    rafc_ramp_type ramp;
    logic [9:0] bus_volt;
    logic [15:0] out_freq;
  } rafc_drive_in_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } rafc_reg_req_type;

  typedef struct packed {
    logic [1:0] sel;
    logic [9:0] level;
    logic [15:0] limit;
    logic [7:0] vgain;
    logic [7:0] fgain;
    logic [15:0] maxf;
    logic [15:0] comp;
    logic [15:0] freq_out;
    logic hold;
    logic active;
    logic [31:0] rdata;
  } rafc_state_type;

endpackage : rafc_pkg

`default_nettype wire

//--- tb/rafc_drive_model.sv
// drive side stand-in: ramp state, bus voltage, output frequency and control tick
// assumes the bench sets levels and tick gap at clock edges; gap 0 stops ticks
`timescale 1ns/1ps
`default_nettype none
module rafc_drive_model (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire rafc_pkg::rafc_ramp_type i_ramp,
  input wire logic [9:0] i_volt,
  input wire logic [15:0] i_freq,
  input wire logic [7:0] i_gap,
  output var rafc_pkg::rafc_drive_in_type o_drive
);
  import rafc_pkg::*;
  logic [7:0] cnt_q;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= 8'h00;
      o_drive <= '0;
    end else begin
      cnt_q <= (cnt_q + 8'h01 >= i_gap) ? 8'h00 : cnt_q + 8'h01;
      o_drive.tick <= (i_gap != 8'h00) && (cnt_q == 8'h00);
      o_drive.ramp <= i_ramp;
      o_drive.bus_volt <= i_volt;
      o_drive.out_freq <= i_freq;
    end
  end
endmodule : rafc_drive_model
`default_nettype wire

//--- tb/tb_regen_avoidance_freq_comp.sv
// self-checking bench for the regeneration avoidance block
// assumes the drive model feeds the drive port; expectations come from a shadow model
`timescale 1ns/1ps
`default_nettype none
module tb_regen_avoidance_freq_comp;
  import rafc_pkg::*;
  localparam int CA[8] = '{8'h04, 8'h04, 8'h08, 8'h08, 8'h0C, 8'h10, 8'h00, 8'h00};
  localparam int CW[8] = '{200, 900, 5000, 9999, 255, 201, 2, 3};
  localparam int CR[8] = '{300, 800, 1000, 9999, 200, 200, 2, 2};
  localparam int LIM[4] = '{0, 600, 1000, 9999};
  logic clk = 1'b0;
  logic rst = 1'b1;
  rafc_drive_in_type drv;
  rafc_reg_req_type req = '0;
  rafc_ramp_type ramp = RAFC_RAMP_STOP;
  logic [9:0] volt = 10'h000;
  logic [15:0] freq = 16'h0000;
  logic [7:0] gap = 8'h00;
  logic [31:0] rdata;
  logic [15:0] cfreq;
  logic act;
  logic stall;
  int miscompares = 0;
  int compares = 0;
  int seed = 32'h1be8e8b8;
  int sel, lvl, lim, vg, fg, mxf, e_act, e_out;
  int comp = 0;
  int hold = 0;
  bit pend = 1'b0;
  always #2.5 clk = ~clk;
  rafc_drive_model u_drv (.i_ref_clk(clk), .i_rst(rst), .i_ramp(ramp), .i_volt(volt), .i_freq(freq),
    .i_gap(gap), .o_drive(drv));
  rafc_top #(.P_CLASS_400V(1'b0)) u_dut (.i_ref_clk(clk), .i_rst(rst), .i_drive(drv), .i_reg(req),
    .o_rd_data(rdata), .o_comp_freq(cfreq), .o_regen_active(act), .o_stall_prev_req(stall));
  function automatic int rnd(input int n);
    return $unsigned($random(seed)) % n;
  endfunction : rnd
  function automatic void step(input rafc_drive_in_type d);
    int en;
    int f;
    f = d.out_freq;
    en = (sel == 1) || (sel == 2 && d.ramp == RAFC_RAMP_CONST);
    e_act = 0;
    if (!en) begin
      comp = (sel == 0 || comp == 0) ? 0 : comp - 1;
      hold = 0;
    end else if (int'(d.bus_volt) >= lvl) begin
      comp += ((int'(d.bus_volt) - lvl + 1) * vg * fg) >>> 12;
      e_act = 1;
    end else if (comp > 0) begin
      comp--;
    end
    if (en && lim != 9999) begin
      if (d.ramp != RAFC_RAMP_DECEL) begin
        if (comp > lim) comp = lim;
        hold = 0;
      end else begin
        if (hold != 0 || comp > lim) begin
          comp = lim;
          hold = 1;
        end
        if (f <= lim / 2) hold = 0;
      end
    end else begin
      hold = 0;
    end
    comp = (f >= mxf) ? 0 : ((comp > mxf - f) ? mxf - f : comp);
    e_out = f + comp;
  endfunction : step
  function automatic int stat_exp();
    return 4 * int'(sel == 1 || (sel == 2 && ramp == RAFC_RAMP_CONST)) + 2 * hold + e_act;
  endfunction : stat_exp
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  task automatic wr(input logic [7:0] a, input int d);
    req <= '{addr: a, wdata: 32'(d), wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input int e);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
    chk(rdata, 32'(e));
  endtask : rd
  task automatic cfg(input int s, input int l, input int li, input int v, input int f, input int m);
    sel = s;
    lvl = l;
    lim = li;
    vg = v;
    fg = f;
    mxf = m;
    wr(8'h00, s);
    wr(8'h04, l);
    wr(8'h08, li);
    wr(8'h0C, v);
    wr(8'h10, f);
    wr(8'h14, m);
  endtask : cfg
  task automatic drive(input rafc_ramp_type r, input int v, input int f, input int g, input int n);
    ramp <= r;
    volt <= 10'(v);
    freq <= 16'(f);
    gap <= 8'(g);
    repeat (n) @(posedge clk);
  endtask : drive
  task automatic stop();
    gap <= 8'h00;
    repeat (4) @(posedge clk);
  endtask : stop
  always @(posedge clk) begin
    if (pend) begin
      chk(32'(cfreq), 32'(e_out));
      chk(32'(act), 32'(e_act));
      chk(32'(stall), 32'(e_act));
    end
    pend = !rst && drv.tick;
    if (pend) step(drv);
  end
  initial begin
    #400us;
    $display("BAD %0t run did not finish", $time);
    miscompares++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h00, 0);
    rd(8'h04, 400);
    rd(8'h08, 600);
    rd(8'h0C, 100);
    rd(8'h10, 100);
    rd(8'h14, 12000);
    rd(8'h20, 0);
    for (int i = 0; i < 8; i++) begin
      wr(8'(CA[i]), CW[i]);
      rd(8'(CA[i]), CR[i]);
    end
    cfg(1, 400, 600, 100, 100, 12000);
    drive(RAFC_RAMP_CONST, 450, 3000, 1, 20);
    for (int i = 20; i >= 0; i--) drive(RAFC_RAMP_DECEL, 450, 50 * i, 1, 1);
    stop();
    rd(8'h1C, comp);
    rd(8'h18, stat_exp());
    for (int k = 0; k < 12; k++) begin
      cfg(k % 3, 300 + rnd(501), LIM[k % 4], rnd(201), rnd(201), 2000 + rnd(10001));
      for (int i = 0; i < 150; i++)
        drive(rafc_ramp_type'(4'h1 << rnd(4)), lvl - 30 + rnd(60), rnd(13000), 1 + k % 3, 1);
      stop();
      rd(8'h1C, comp);
      rd(8'h18, stat_exp());
    end
    rst <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    chk(32'(cfreq), 32'h0);
    chk(32'(act), 32'h0);
    chk(32'(stall), 32'h0);
    rst <= 1'b0;
    comp = 0;
    hold = 0;
    @(posedge clk);
    rd(8'h00, 0);
    rd(8'h08, 600);
    finish_test();
  end
endmodule : tb_regen_avoidance_freq_comp
`default_nettype wire
